/* File: dv/tb_test_pattern_and_map_load.sv */
`timescale 1ns/1ns
module tb_test_pattern_and_map_load;
    import pattern_pkg::*;
    logic        clock, srst, reg_write, map_loaded, serial_clock_in_enable;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  interface_select, active_mapping;
    logic        sample_valid, sample_ready, mapper_valid, mapper_ready;
    logic [13:0] sample_data;
    logic [17:0] mapper_data;
    logic [17:0] got[$];
    int          miscompares, total_checks, cycles;

    test_pattern_and_map_load test_pattern_and_map_load_i (.clock(clock), .srst(srst),
        .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .interface_select(interface_select),
        .active_mapping(active_mapping), .map_loaded(map_loaded),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_data(sample_data), .mapper_valid(mapper_valid),
        .mapper_ready(mapper_ready), .mapper_data(mapper_data),
        .serial_clock_in_enable(serial_clock_in_enable));

    // ****************************************
    // Clock, monitor and timeout.
    // ****************************************
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (mapper_valid === 1'b1 && mapper_ready === 1'b1) got.push_back(mapper_data);
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            conclude();
        end
    end

    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        reg_addr = a;
        repeat (3) @(negedge clock);
        check("reg_rdata", reg_rdata, exp);
    endtask : rd_check

    task automatic flush();
        mapper_ready = 1'b1;
        repeat (8) @(negedge clock);
        got.delete();
    endtask : flush

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic regs_reset_and_mask();
        logic [7:0] addrs[6] = '{8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h17};
        logic [7:0] wdat[6]  = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'h10, 8'hff};
        logic [7:0] masks[6] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'h10, 8'h00};
        for (int i = 0; i < 6; i++) rd_check(addrs[i], 8'h00);
        for (int i = 0; i < 6; i++) wr(addrs[i], wdat[i]);
        for (int i = 0; i < 6; i++) rd_check(addrs[i], masks[i]);
        check("serial_clock_in_enable", serial_clock_in_enable, 1);
    endtask : regs_reset_and_mask

    task automatic map_load();
        int n;
        interface_select = 4'ha;
        wr(8'h13, 8'h00);
        n = 0;
        while (map_loaded !== 1'b1 && n < 6)
        begin
            @(negedge clock);
            n++;
        end
        check("map_loaded", map_loaded, 1);
        check("active_mapping", active_mapping, 4'ha);
        @(negedge clock);
        check("map_loaded pulse", map_loaded, 0);
        for (int a = 8'h14; a <= 8'h18; a++) rd_check(a[7:0], 8'h00);
        check("serial_clock_in_enable", serial_clock_in_enable, 0);
    endtask : map_load

    task automatic normal_stall();
        logic [17:0] exp[$];
        flush();
        mapper_ready = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            @(negedge clock);
            sample_valid = 1'b1;
            sample_data  = 14'h1000 + 14'(exp.size());
            if (sample_ready === 1'b1) exp.push_back({sample_data, 4'h0});
        end
        @(negedge clock);
        sample_valid = 1'b0;
        check("sample_ready full", sample_ready, 0);
        check("accepted", exp.size(), 2);
        mapper_ready = 1'b1;
        repeat (8) @(negedge clock);
        check("drained", got.size(), exp.size());
        for (int i = 0; i < exp.size() && i < got.size(); i++)
            check("normal data", got[i], exp[i]);
    endtask : normal_stall

    task automatic pattern_run(input logic [7:0] hi, input logic [17:0] val, input bit ramp);
        logic [17:0] d;
        wr(8'h14, val[7:0]);
        wr(8'h15, val[15:8]);
        wr(8'h16, hi | {6'h0, val[17:16]});
        flush();
        mapper_ready = 1'b0;
        repeat (3) @(negedge clock);
        mapper_ready = 1'b1;
        repeat (12) @(negedge clock);
        check("pattern words", got.size() > 8, 1);
        for (int k = 3; k < got.size(); k++)
        begin
            d = got[k] - got[k-1];
            if (ramp)
                check("ramp step", d, val);
            else
                check("constant", got[k], val);
        end
    endtask : pattern_run

    // ****************************************
    // Main sequence.
    // ****************************************
    initial
    begin
        srst = 1'b1;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        interface_select = 4'h3;
        sample_valid = 1'b0;
        sample_data = 14'h0;
        mapper_ready = 1'b0;
        miscompares = 0;
        total_checks = 0;
        cycles = 0;
        repeat (16) @(negedge clock);
        srst = 1'b0;
        regs_reset_and_mask();
        map_load();
        normal_stall();
        pattern_run(8'h0c, 18'h21234, 1'b0);
        interface_select = 4'h5;
        pattern_run(8'h0c, 18'h21234, 1'b0);
        pattern_run(8'h08, 18'h00010, 1'b1);
        pattern_run(8'h08, 18'h20000, 1'b1);
        conclude();
    end
endmodule : tb_test_pattern_and_map_load

/* File: verilog/pattern_pkg.sv */
package pattern_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          PAT_W           = 18;
    localparam int          SAMPLE_W        = 18;
    localparam int          NATIVE_W        = 14;
    localparam int          SEL_W           = 3;
    localparam logic [7:0]  ADDR_LOAD       = 8'h13;
    localparam logic [7:0]  ADDR_PAT_LOW    = 8'h14;
    localparam logic [7:0]  ADDR_PAT_MID    = 8'h15;
    localparam logic [7:0]  ADDR_PAT_HIGH   = 8'h16;
    localparam logic [7:0]  ADDR_SCLK_IN    = 8'h18;
    localparam logic [7:0]  RESET_VALUE     = 8'h00;
    localparam int          LOAD_BIT        = 0;
    localparam int          SEL_LSB         = 2;
    localparam int          PAT_HIGH_LSB    = 0;
    localparam int          SCLK_EN_BIT     = 4;
    localparam logic [7:0]  LOAD_MASK       = 8'h01;
    localparam logic [7:0]  HIGH_MASK       = 8'h1f;
    localparam logic [7:0]  SCLK_MASK       = 8'h10;
    localparam logic [2:0]  SEL_NORMAL      = 3'h0;
    localparam logic [2:0]  SEL_RAMP        = 3'h2;
    localparam logic [2:0]  SEL_CONST       = 3'h3;
    localparam int          MAP_W           = 4;
endpackage : pattern_pkg

/* File: verilog/skid_buffer.sv */
`timescale 1ns/1ns
module skid_buffer #(
    parameter int WIDTH = 18
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // Two-entry buffer: head feeds the output, spare catches one word on stall.
    logic [WIDTH-1:0] head_q;
    logic [WIDTH-1:0] head_d;
    logic [WIDTH-1:0] spare_q;
    logic [WIDTH-1:0] spare_d;
    logic [1:0]       count_q;
    logic [1:0]       count_d;
    logic             push;
    logic             pop;

    always_comb
    begin
        push    = in_valid && (count_q != 2'h2);
        pop     = (count_q != 2'h0) && out_ready;
        head_d  = head_q;
        spare_d = spare_q;
        count_d = count_q;
        if (pop && count_q == 2'h2)
        begin
            head_d = spare_q;
        end
        if (push)
        begin
            if (count_q == 2'h0 || (pop && count_q == 2'h1))
            begin
                head_d = in_data;
            end
            else if (pop && count_q == 2'h2)
            begin
                spare_d = in_data;
            end
            else
            begin
                spare_d = in_data;
            end
        end
        count_d = count_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            head_q  <= '0;
            spare_q <= '0;
            count_q <= 2'h0;
        end
        else
        begin
            head_q  <= head_d;
            spare_q <= spare_d;
            count_q <= count_d;
        end
    end

    assign in_ready  = (count_q != 2'h2);
    assign out_valid = (count_q != 2'h0);
    assign out_data  = head_q;
endmodule : skid_buffer

/* File: verilog/test_pattern_and_map_load.sv */
`timescale 1ns/1ns
module test_pattern_and_map_load
    import pattern_pkg::*;
#(
    parameter int OUT_W = pattern_pkg::SAMPLE_W
) (
    input  wire logic                             clock,
    input  wire logic                             srst,
    input  wire logic                             reg_write,
    input  wire logic [pattern_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [pattern_pkg::DATA_W-1:0]   reg_wdata,
    output logic      [pattern_pkg::DATA_W-1:0]   reg_rdata,
    input  wire logic [pattern_pkg::MAP_W-1:0]    interface_select,
    output logic      [pattern_pkg::MAP_W-1:0]    active_mapping,
    output logic                                  map_loaded,
    input  wire logic                             sample_valid,
    output logic                                  sample_ready,
    input  wire logic [pattern_pkg::NATIVE_W-1:0] sample_data,
    output logic                                  mapper_valid,
    input  wire logic                             mapper_ready,
    output logic      [OUT_W-1:0]                 mapper_data,
    output logic                                  serial_clock_in_enable
);
    import pattern_pkg::*;

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]         load_q;
    logic [7:0]         load_d;
    logic [7:0]         low_q;
    logic [7:0]         low_d;
    logic [7:0]         mid_q;
    logic [7:0]         mid_d;
    logic [7:0]         high_q;
    logic [7:0]         high_d;
    logic [7:0]         sclk_q;
    logic [7:0]         sclk_d;
    logic [MAP_W-1:0]   map_q;
    logic [MAP_W-1:0]   map_d;
    logic               loaded_q;
    logic               loaded_d;
    logic [7:0]         rdata_q;
    logic [7:0]         rdata_d;
    logic               fall;

    always_comb
    begin
        load_d   = load_q;
        low_d    = low_q;
        mid_d    = mid_q;
        high_d   = high_q;
        sclk_d   = sclk_q;
        map_d    = map_q;
        loaded_d = 1'b0;
        fall     = load_q[LOAD_BIT] && reg_write && reg_addr == ADDR_LOAD
                   && !reg_wdata[LOAD_BIT];
        if (reg_write)
        begin
            case (reg_addr)
                ADDR_LOAD:     load_d = reg_wdata & LOAD_MASK;
                ADDR_PAT_LOW:  low_d  = reg_wdata;
                ADDR_PAT_MID:  mid_d  = reg_wdata;
                ADDR_PAT_HIGH: high_d = reg_wdata & HIGH_MASK;
                ADDR_SCLK_IN:  sclk_d = reg_wdata & SCLK_MASK;
                default:       load_d = load_q;
            endcase
        end
        if (fall)
        begin
            map_d    = interface_select;
            loaded_d = 1'b1;
            low_d    = RESET_VALUE;
            mid_d    = RESET_VALUE;
            high_d   = RESET_VALUE;
            sclk_d   = RESET_VALUE;
        end
        case (reg_addr)
            ADDR_LOAD:     rdata_d = load_q;
            ADDR_PAT_LOW:  rdata_d = low_q;
            ADDR_PAT_MID:  rdata_d = mid_q;
            ADDR_PAT_HIGH: rdata_d = high_q;
            ADDR_SCLK_IN:  rdata_d = sclk_q;
            default:       rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            load_q   <= RESET_VALUE;
            low_q    <= RESET_VALUE;
            mid_q    <= RESET_VALUE;
            high_q   <= RESET_VALUE;
            sclk_q   <= RESET_VALUE;
            map_q    <= '0;
            loaded_q <= 1'b0;
            rdata_q  <= 8'h00;
        end
        else
        begin
            load_q   <= load_d;
            low_q    <= low_d;
            mid_q    <= mid_d;
            high_q   <= high_d;
            sclk_q   <= sclk_d;
            map_q    <= map_d;
            loaded_q <= loaded_d;
            rdata_q  <= rdata_d;
        end
    end

    // ************************************************************
    // Pattern source
    // ************************************************************
    logic [PAT_W-1:0]   pattern;
    logic [SEL_W-1:0]   sel;
    logic [OUT_W-1:0]   ramp_q;
    logic [OUT_W-1:0]   ramp_d;
    logic [OUT_W-1:0]   src_data;
    logic               src_valid;
    logic               buf_ready;

    assign pattern = {high_q[PAT_HIGH_LSB+1:PAT_HIGH_LSB], mid_q, low_q};
    assign sel     = high_q[SEL_LSB+SEL_W-1:SEL_LSB];

    always_comb
    begin
        ramp_d = ramp_q;
        if (sel != SEL_RAMP)
        begin
            ramp_d = '0;
        end
        else if (buf_ready)
        begin
            ramp_d = ramp_q + OUT_W'(pattern);
        end
        // Samples are MSB-aligned with zero-filled LSBs; patterns drive the full OUT_W-bit output directly.
        case (sel)
            SEL_NORMAL:
            begin
                src_valid = sample_valid;
                src_data  = {sample_data, {(OUT_W-NATIVE_W){1'b0}}};
            end
            SEL_RAMP:
            begin
                src_valid = 1'b1;
                src_data  = ramp_q;
            end
            SEL_CONST:
            begin
                src_valid = 1'b1;
                src_data  = OUT_W'(pattern);
            end
            default:
            begin
                src_valid = 1'b1;
                src_data  = '0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ramp_q                 <= '0;
            active_mapping         <= '0;
            map_loaded             <= 1'b0;
            reg_rdata              <= 8'h00;
            serial_clock_in_enable <= 1'b0;
        end
        else
        begin
            ramp_q                 <= ramp_d;
            active_mapping         <= map_q;
            map_loaded             <= loaded_q;
            reg_rdata              <= rdata_q;
            serial_clock_in_enable <= sclk_q[SCLK_EN_BIT];
        end
    end

    assign sample_ready = (sel == SEL_NORMAL) && buf_ready;

    skid_buffer #(
        .WIDTH (OUT_W)
    ) u_buffer (
        .clock     (clock),
        .srst      (srst),
        .in_valid  (src_valid),
        .in_ready  (buf_ready),
        .in_data   (src_data),
        .out_valid (mapper_valid),
        .out_ready (mapper_ready),
        .out_data  (mapper_data)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    sequence load_fall_s;
        reg_write && reg_addr == ADDR_LOAD && !reg_wdata[LOAD_BIT] && load_q[LOAD_BIT];
    endsequence

    sequence const_hold_s;
        sel == SEL_CONST ##1 sel == SEL_CONST && $stable(pattern) && $changed(interface_select);
    endsequence

    map_follows_load_a: assert property (@(posedge clock) disable iff (srst)
        load_fall_s |=> map_q == $past(interface_select))
        else $error("Mapping not loaded on load pulse.");
    load_clears_a: assert property (@(posedge clock) disable iff (srst)
        load_fall_s |=> low_q == 8'h00 && mid_q == 8'h00 && high_q == 8'h00)
        else $error("Load did not clear pattern registers.");
    const_out_a: assert property (@(posedge clock) disable iff (srst)
        sel == SEL_CONST |-> src_data == OUT_W'(pattern))
        else $error("Constant pattern wrong.");
    normal_out_a: assert property (@(posedge clock) disable iff (srst)
        sel == SEL_NORMAL |-> src_data[OUT_W-1:OUT_W-NATIVE_W] == sample_data)
        else $error("Sample not MSB aligned.");
    ramp_step_a: assert property (@(posedge clock) disable iff (srst)
        sel == SEL_RAMP && buf_ready ##1 sel == SEL_RAMP
        |-> ramp_q == $past(ramp_q) + OUT_W'($past(pattern)))
        else $error("Ramp step wrong.");
    sclk_en_a: assert property (@(posedge clock) disable iff (srst)
        ##1 serial_clock_in_enable == $past(sclk_q[SCLK_EN_BIT]))
        else $error("Serial clock enable mismatch.");
    sample_gate_a: assert property (@(posedge clock) disable iff (srst)
        sel != SEL_NORMAL |-> !sample_ready)
        else $error("Samples taken during pattern.");
    format_free_a: assert property (@(posedge clock) disable iff (srst)
        const_hold_s |-> src_data == $past(src_data) && src_data == OUT_W'(pattern))
        else $error("Pattern changed by format.");
endmodule : test_pattern_and_map_load
